// file: tocm_consts.svh
/*
 * Register offsets, field positions, reset values and codes for the timer
 * output compare channel. Assumes byte addresses on a 32-bit Wishbone bus.
 */
`ifndef TOCM_CONSTS_SVH
`define TOCM_CONSTS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define TOCM_ADR_W 8
`define TOCM_ADR_MODE 8'h18
`define TOCM_ADR_CCEN 8'h20
`define TOCM_ADR_CMPV 8'h34
`define TOCM_ADR_PROT 8'h40
`define TOCM_ADR_STAT 8'h44

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TOCM_DIR_LO 0
`define TOCM_DIR_HI 1
`define TOCM_FEN_BIT 2
`define TOCM_PEN_BIT 3
`define TOCM_MOD_LO 4
`define TOCM_MOD_HI 6
`define TOCM_CHEN_BIT 0
`define TOCM_PROT_LO 0
`define TOCM_PROT_HI 1
`define TOCM_STAT_REF_BIT 0
`define TOCM_STAT_MATCH_BIT 1

// ---------------------------------------------------------------
// codes and reset values
// ---------------------------------------------------------------
`define TOCM_DIR_OUT 2'h0
`define TOCM_PROT_LOCK 2'h3
`define TOCM_RST_DIR 2'h0
`define TOCM_RST_PROT 2'h0
`define TOCM_RST_CMP 16'h0000
`define TOCM_CMP_W 16

`endif

// file: tocm_pkg.sv
/*
 * Types shared by the output compare channel modules.
 * Assumes nothing of its surroundings.
 */
package tocm_pkg;
  // ---------------------------------------------------------------
  // compare output modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TOCM_FREEZE = 3'h0,
    TOCM_SET = 3'h1,
    TOCM_CLR = 3'h2,
    TOCM_TOGGLE = 3'h3,
    TOCM_FORCE_LO = 3'h4,
    TOCM_FORCE_HI = 3'h5,
    TOCM_PWM1 = 3'h6,
    TOCM_PWM2 = 3'h7
  } tocm_mode_t;
endpackage

// file: tocm_preload.sv
/*
 * Compare value buffer and active compare register.
 * Assumes write and update strobes are one-cycle pulses on i_sys_clk.
 */
`timescale 1ns/10ps
`include "tocm_consts.svh"
module tocm_preload #(
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // software write
  input wire logic i_wr,
  input wire logic [CNT_W-1:0] i_wdata,
  input wire logic i_preload,
  // timer update event
  input wire logic i_update,
  // values
  output logic [CNT_W-1:0] o_buf,
  output logic [CNT_W-1:0] o_active
);
  // ---------------------------------------------------------------
  // buffer and active value
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_buf <= CNT_W'(`TOCM_RST_CMP);
    end else if (i_ce && i_wr) begin
      o_buf <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_active <= CNT_W'(`TOCM_RST_CMP);
    end else if (i_ce) begin
      if (i_update && i_preload) begin
        o_active <= o_buf;
      end else if (i_wr && !i_preload) begin
        o_active <= i_wdata;
      end
    end
  end
endmodule

// file: tocm_refgen.sv
/*
 * Reference level generator for one compare channel.
 * Assumes counter and compare values are synchronous to i_sys_clk.
 */
`timescale 1ns/10ps
module tocm_refgen import tocm_pkg::*; #(
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // configuration
  input wire logic i_out_dir,
  input wire tocm_mode_t i_mode,
  input wire logic i_fast,
  // timer side
  input wire logic i_trigger,
  input wire logic [CNT_W-1:0] i_cnt,
  input wire logic [CNT_W-1:0] i_cmp,
  // results
  output logic o_ref,
  output logic o_match
);
  logic equal;
  logic below;
  logic above;
  logic prev_below;
  logic prev_above;
  logic first_pwm;
  logic next_ref;
  tocm_mode_t prev_mode;

  assign equal = (i_cnt == i_cmp);
  assign below = (i_cnt < i_cmp);
  assign above = (i_cnt > i_cmp);
  assign first_pwm = (prev_mode == TOCM_FREEZE);

  // ---------------------------------------------------------------
  // next level per mode
  // ---------------------------------------------------------------
  always_comb begin
    next_ref = o_ref;
    case (i_mode)
      TOCM_FREEZE: next_ref = o_ref;
      TOCM_SET: if (equal) next_ref = 1'b1;
      TOCM_CLR: if (equal) next_ref = 1'b0;
      TOCM_TOGGLE: if (equal) next_ref = ~o_ref;
      TOCM_FORCE_LO: next_ref = 1'b0;
      TOCM_FORCE_HI: next_ref = 1'b1;
      TOCM_PWM1: begin
        if (below != prev_below || first_pwm) next_ref = below;
        if (i_fast && i_trigger) next_ref = (i_cmp != '0);
      end
      TOCM_PWM2: begin
        if (above != prev_above || first_pwm) next_ref = above;
        if (i_fast && i_trigger) next_ref = 1'b0;
      end
      default: next_ref = o_ref;
    endcase
    if (!i_out_dir) next_ref = o_ref;
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ref <= 1'b0;
      o_match <= 1'b0;
      prev_below <= 1'b0;
      prev_above <= 1'b0;
      prev_mode <= TOCM_FREEZE;
    end else if (i_ce) begin
      o_ref <= next_ref;
      o_match <= equal;
      prev_below <= below;
      prev_above <= above;
      prev_mode <= i_mode;
    end
  end
endmodule

// file: tocm_top.sv
/*
 * Output compare channel: Wishbone classic register slave, mode control,
 * compare preload and reference level generation.
 * Assumes counter, update and trigger inputs come from the timer core on
 * i_sys_clk, update and trigger being one-cycle pulses.
 */
`timescale 1ns/10ps
`include "tocm_consts.svh"

// Notes on behaviour
// - fast enable lets a trigger set the PWM level one cycle later.
// - preload off: a written compare value is used at once.
// - preload on: written value waits in a buffer until an update event.
// - lock level 3 on an output channel blocks preload and mode writes.
// - mode 000 freeze: matches leave the reference level alone.
// - mode 001 drives the reference high on a match.
// - mode 010 drives the reference low on a match.
// - mode 011 inverts the reference on each match.
// - mode 100 forces the reference low, mode 101 forces it high.
// - mode 110: high while counter below compare, else low.
// - mode 111: high while counter above compare, else low.
// - PWM updates on outcome change and on switch from freeze.
// - mode and fast enable fields act only while direction select is 00.
// - direction select is writable only while the channel is disabled.
module tocm_top import tocm_pkg::*; #(
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [`TOCM_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // timer core
  input wire logic [CNT_W-1:0] i_cnt,
  input wire logic i_update,
  input wire logic i_trigger,
  // channel outputs
  output logic o_compare_reference_level,
  output logic o_channel_enable
);
  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (CNT_W < 1 || CNT_W > `TOCM_CMP_W) begin : g_bad_width
    $error("CNT_W must lie between 1 and 16");
  end

  logic [1:0] channel_direction_select;
  logic compare_fast_enable;
  logic compare_preload_enable;
  tocm_mode_t compare_output_mode;
  logic [1:0] protection_level;
  logic [CNT_W-1:0] cmp_buf;
  logic [CNT_W-1:0] cmp_active;
  logic match_flag;
  logic take;
  logic wr;
  logic mode_wr;
  logic ccen_wr;
  logic cmp_wr;
  logic prot_wr;
  logic out_dir;
  logic mode_lock;
  logic [CNT_W-1:0] cmp_wdata;
  logic [31:0] next_rdata;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr = take && i_wb_we;
  assign mode_wr = wr && (i_wb_adr == `TOCM_ADR_MODE) && i_wb_sel[0];
  assign ccen_wr = wr && (i_wb_adr == `TOCM_ADR_CCEN) && i_wb_sel[0];
  assign prot_wr = wr && (i_wb_adr == `TOCM_ADR_PROT) && i_wb_sel[0];
  assign cmp_wr = wr && (i_wb_adr == `TOCM_ADR_CMPV) && (i_wb_sel[1:0] != 2'h0);
  assign out_dir = (channel_direction_select == `TOCM_DIR_OUT);
  assign mode_lock = (protection_level == `TOCM_PROT_LOCK) && out_dir;

  // byte lanes merge into the buffered compare value
  always_comb begin
    logic [15:0] merged;
    merged = 16'h0000;
    merged[CNT_W-1:0] = cmp_buf;
    if (i_wb_sel[0]) merged[7:0] = i_wb_dat[7:0];
    if (i_wb_sel[1]) merged[15:8] = i_wb_dat[15:8];
    cmp_wdata = merged[CNT_W-1:0];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
    end else if (i_ce) begin
      o_wb_ack <= take;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_wb_adr)
      `TOCM_ADR_MODE: begin
        next_rdata[`TOCM_DIR_HI:`TOCM_DIR_LO] = channel_direction_select;
        next_rdata[`TOCM_FEN_BIT] = compare_fast_enable;
        next_rdata[`TOCM_PEN_BIT] = compare_preload_enable;
        next_rdata[`TOCM_MOD_HI:`TOCM_MOD_LO] = compare_output_mode;
      end
      `TOCM_ADR_CCEN: next_rdata[`TOCM_CHEN_BIT] = o_channel_enable;
      `TOCM_ADR_CMPV: next_rdata[CNT_W-1:0] = cmp_buf;
      `TOCM_ADR_PROT: next_rdata[`TOCM_PROT_HI:`TOCM_PROT_LO] = protection_level;
      `TOCM_ADR_STAT: begin
        next_rdata[`TOCM_STAT_REF_BIT] = o_compare_reference_level;
        next_rdata[`TOCM_STAT_MATCH_BIT] = match_flag;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (i_ce && take) begin
      o_wb_dat <= i_wb_we ? 32'h0000_0000 : next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // channel mode control
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      channel_direction_select <= `TOCM_RST_DIR;
    end else if (i_ce && mode_wr && !o_channel_enable) begin
      channel_direction_select <= i_wb_dat[`TOCM_DIR_HI:`TOCM_DIR_LO];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      compare_fast_enable <= 1'b0;
    end else if (i_ce && mode_wr) begin
      compare_fast_enable <= i_wb_dat[`TOCM_FEN_BIT];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      compare_preload_enable <= 1'b0;
      compare_output_mode <= TOCM_FREEZE;
    end else if (i_ce && mode_wr && !mode_lock) begin
      compare_preload_enable <= i_wb_dat[`TOCM_PEN_BIT];
      compare_output_mode <= tocm_mode_t'(i_wb_dat[`TOCM_MOD_HI:`TOCM_MOD_LO]);
    end
  end

  // ---------------------------------------------------------------
  // channel enable and protection level
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_channel_enable <= 1'b0;
    end else if (i_ce && ccen_wr) begin
      o_channel_enable <= i_wb_dat[`TOCM_CHEN_BIT];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      protection_level <= `TOCM_RST_PROT;
    end else if (i_ce && prot_wr) begin
      protection_level <= i_wb_dat[`TOCM_PROT_HI:`TOCM_PROT_LO];
    end
  end

  // ---------------------------------------------------------------
  // compare value and reference level
  // ---------------------------------------------------------------
  tocm_preload #(
    .CNT_W(CNT_W)
  ) u_preload (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_wr(cmp_wr),
    .i_wdata(cmp_wdata),
    .i_preload(compare_preload_enable),
    .i_update(i_update),
    .o_buf(cmp_buf),
    .o_active(cmp_active)
  );

  tocm_refgen #(
    .CNT_W(CNT_W)
  ) u_refgen (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_out_dir(out_dir),
    .i_mode(compare_output_mode),
    .i_fast(compare_fast_enable),
    .i_trigger(i_trigger),
    .i_cnt(i_cnt),
    .i_cmp(cmp_active),
    .o_ref(o_compare_reference_level),
    .o_match(match_flag)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  logic ref_q;
  logic cmp_below;
  assign ref_q = o_compare_reference_level;
  assign cmp_below = (i_cnt < cmp_active);

  sequence freeze_step_s;
    compare_output_mode == TOCM_FREEZE && i_ce;
  endsequence

  sequence enter_pwm1_s;
    compare_output_mode == TOCM_PWM1 && out_dir && i_ce && !i_trigger;
  endsequence

  preload_off_a: assert property (
    (cmp_wr && !compare_preload_enable && i_ce) |=> (cmp_active == $past(cmp_wdata))
  ) else $error("compare value not used at once with preload off");

  preload_hold_a: assert property (
    (cmp_wr && compare_preload_enable && !i_update && i_ce)
      |=> (cmp_active == $past(cmp_active))
  ) else $error("buffered compare value applied before update");

  update_copy_a: assert property (
    (i_update && compare_preload_enable && i_ce) |=> (cmp_active == $past(cmp_buf))
  ) else $error("update did not copy buffered compare value");

  lock_mode_a: assert property (
    (mode_wr && mode_lock && i_ce)
      |=> (compare_output_mode == $past(compare_output_mode))
        && (compare_preload_enable == $past(compare_preload_enable))
  ) else $error("locked mode or preload bit changed");

  dir_lock_a: assert property (
    (mode_wr && o_channel_enable && i_ce)
      |=> (channel_direction_select == $past(channel_direction_select))
  ) else $error("direction changed while channel enabled");

  freeze_hold_a: assert property (
    (compare_output_mode == TOCM_FREEZE && i_ce) |=> (ref_q == $past(ref_q))
  ) else $error("reference moved in freeze mode");

  match_set_a: assert property (
    (compare_output_mode == TOCM_SET && out_dir && i_cnt == cmp_active && i_ce) |=> ref_q
  ) else $error("reference not high after match");

  match_clr_a: assert property (
    (compare_output_mode == TOCM_CLR && out_dir && i_cnt == cmp_active && i_ce) |=> !ref_q
  ) else $error("reference not low after match");

  match_toggle_a: assert property (
    (compare_output_mode == TOCM_TOGGLE && out_dir && i_cnt == cmp_active && i_ce)
      |=> (ref_q != $past(ref_q))
  ) else $error("reference did not toggle on match");

  force_high_a: assert property (
    (compare_output_mode == TOCM_FORCE_HI && out_dir && i_ce) [*2] |-> ref_q
  ) else $error("reference not forced high");

  pwm_entry_a: assert property (
    freeze_step_s ##1 enter_pwm1_s |=> (ref_q == $past(cmp_below))
  ) else $error("reference not set on entry to pwm mode");

  fast_trig_a: assert property (
    (compare_output_mode == TOCM_PWM2 && compare_fast_enable && i_trigger && out_dir && i_ce)
      |=> !ref_q
  ) else $error("fast trigger did not act in one cycle");

  dir_gate_a: assert property (
    (!out_dir && i_ce) |=> (ref_q == $past(ref_q))
  ) else $error("reference moved while channel is an input");

  bus_ack_a: assert property (
    (i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce) |=> o_wb_ack ##1 !o_wb_ack
  ) else $error("wishbone ack not a single cycle pulse");
endmodule

// file: timer_output_compare_mode_tb_top.sv
/*
 * Self-checking bench for the output compare channel top module.
 * Assumes the Wishbone slave acks one cycle after taking a request and
 * that the reference level follows a counter match by one cycle.
 */
`timescale 1ns/10ps
`include "tocm_consts.svh"
module timer_output_compare_mode_tb_top import tocm_pkg::*;;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic [15:0] i_cnt = 16'h0000;
  logic i_update = 1'b0;
  logic i_trigger = 1'b0;
  logic o_compare_reference_level;
  logic o_channel_enable;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  integer seed = 46188;
  logic [31:0] q;
  logic [15:0] c, b;
  logic [2:0] pre [8] = '{3'h4, 3'h5, 3'h4, 3'h5, 3'h5, 3'h4, 3'h4, 3'h5};
  logic [2:0] md [8] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h0, 3'h0};

  tocm_top #(.CNT_W(16)) u_tocm_top (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_cnt(i_cnt), .i_update(i_update), .i_trigger(i_trigger),
    .o_compare_reference_level(o_compare_reference_level),
    .o_channel_enable(o_channel_enable)
  );

  always #5 i_sys_clk = ~i_sys_clk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      results();
    end
  end

  // classic single cycle; read data taken at the ack edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] rq);
    int n;
    @(posedge i_sys_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_sel <= 4'hf;
    i_wb_dat <= d;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    rq = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
    check("wb ack", n < 50, 1'b1);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] dummy;
    wb(1'b1, adr, d, dummy);
  endtask

  task automatic rd(input logic [7:0] adr, output logic [31:0] rq);
    wb(1'b0, adr, 32'h0, rq);
  endtask

  // counter value seen by the design at the next edge, result checked after it
  task automatic step(input logic [15:0] v);
    @(posedge i_sys_clk);
    i_cnt <= v;
    @(posedge i_sys_clk);
    #1;
  endtask

  task automatic pulse_trig();
    @(posedge i_sys_clk);
    i_trigger <= 1'b1;
    @(posedge i_sys_clk);
    i_trigger <= 1'b0;
    #1;
  endtask

  function automatic logic [31:0] mw(input logic [1:0] dir, input logic fen,
                                     input logic pen, input logic [2:0] m);
    return {25'h0, m, pen, fen, dir};
  endfunction

  // reference level after one match cycle, starting from a forced level
  function automatic logic exp_match(input logic [2:0] p, input logic [2:0] m);
    case (m)
      3'h0: return p == 3'h5;
      3'h1: return 1'b1;
      3'h3: return p != 3'h5;
      3'h5: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] rnd_cmp();
    return 16'h1000 + 16'($unsigned($random(seed)) % 32'h6000);
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1;
    check("ref after reset", o_compare_reference_level, 1'b0);
    check("enable after reset", o_channel_enable, 1'b0);
    rd(`TOCM_ADR_MODE, q);
    check("mode reset", q, 32'h0);
    rd(`TOCM_ADR_CMPV, q);
    check("compare reset", q, 32'h0);
    rd(`TOCM_ADR_PROT, q);
    check("protection reset", q, 32'h0);
    wr(8'h08, 32'hffff);
    rd(8'h08, q);
    check("unmapped read", q, 32'h0);
    $display("test reset values done");

    for (int i = 0; i < 8; i++) begin
      c = rnd_cmp();
      step(c ^ 16'h8000);
      wr(`TOCM_ADR_CMPV, c);
      wr(`TOCM_ADR_MODE, mw(2'h0, 1'b0, 1'b0, pre[i]));
      wr(`TOCM_ADR_MODE, mw(2'h0, 1'b0, 1'b0, md[i]));
      step(c ^ 16'h8000);
      // counter meets compare for exactly one edge
      @(posedge i_sys_clk);
      i_cnt <= c;
      @(posedge i_sys_clk);
      i_cnt <= c ^ 16'h8000;
      step(c ^ 16'h8000);
      check("match level", o_compare_reference_level, exp_match(pre[i], md[i]));
    end
    rd(`TOCM_ADR_STAT, q);
    check("status ref", q, 32'h1);
    $display("test match modes done");

    c = rnd_cmp();
    b = c + 16'h0400;
    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b0, 1'b0, 3'h4));
    wr(`TOCM_ADR_CMPV, c);
    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b0, 1'b1, 3'h1));
    wr(`TOCM_ADR_CMPV, b);
    step(b);
    step(16'h0000);
    check("preload held", o_compare_reference_level, 1'b0);
    rd(`TOCM_ADR_CMPV, q);
    check("buffered value", q, {16'h0, b});
    @(posedge i_sys_clk);
    i_update <= 1'b1;
    @(posedge i_sys_clk);
    i_update <= 1'b0;
    i_cnt <= b;
    @(posedge i_sys_clk);
    #1;
    check("update copies", o_compare_reference_level, 1'b1);
    $display("test preload done");

    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b0, 1'b0, 3'h4));
    wr(`TOCM_ADR_PROT, 32'h3);
    rd(`TOCM_ADR_PROT, q);
    check("protection rw", q, 32'h3);
    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b1, 1'b1, 3'h5));
    rd(`TOCM_ADR_MODE, q);
    check("locked mode", q, mw(2'h0, 1'b1, 1'b0, 3'h4));
    check("locked ref", o_compare_reference_level, 1'b0);
    wr(`TOCM_ADR_MODE, mw(2'h1, 1'b0, 1'b1, 3'h5));
    rd(`TOCM_ADR_MODE, q);
    check("locked dir write", q, mw(2'h1, 1'b0, 1'b0, 3'h4));
    wr(`TOCM_ADR_MODE, mw(2'h1, 1'b0, 1'b1, 3'h5));
    rd(`TOCM_ADR_MODE, q);
    check("input unlocked", q, mw(2'h1, 1'b0, 1'b1, 3'h5));
    check("input holds ref", o_compare_reference_level, 1'b0);
    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b0, 1'b0, 3'h5));
    step(16'h0000);
    check("output force high", o_compare_reference_level, 1'b1);
    wr(`TOCM_ADR_PROT, 32'h0);
    wr(`TOCM_ADR_CCEN, 32'h1);
    check("channel enabled", o_channel_enable, 1'b1);
    wr(`TOCM_ADR_MODE, mw(2'h2, 1'b0, 1'b0, 3'h5));
    rd(`TOCM_ADR_MODE, q);
    check("dir write blocked", q, mw(2'h0, 1'b0, 1'b0, 3'h5));
    wr(`TOCM_ADR_CCEN, 32'h0);
    check("channel disabled", o_channel_enable, 1'b0);
    $display("test protection done");

    c = rnd_cmp();
    wr(`TOCM_ADR_CMPV, c);
    step(c + 16'h0800);
    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b0, 1'b0, 3'h0));
    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b0, 1'b1, 3'h6));
    step(c + 16'h0800);
    check("pwm1 from freeze", o_compare_reference_level, 1'b0);
    pulse_trig();
    check("slow trigger", o_compare_reference_level, 1'b0);
    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b1, 1'b1, 3'h6));
    pulse_trig();
    check("fast trigger", o_compare_reference_level, 1'b1);
    step(c + 16'h0800);
    step(c - 16'h0800);
    check("pwm1 below", o_compare_reference_level, 1'b1);
    step(c);
    check("pwm1 equal", o_compare_reference_level, 1'b0);
    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b0, 1'b0, 3'h0));
    step(c + 16'h0800);
    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b1, 1'b1, 3'h7));
    step(c + 16'h0800);
    check("pwm2 from freeze", o_compare_reference_level, 1'b1);
    step(c);
    check("pwm2 equal", o_compare_reference_level, 1'b0);
    step(c - 16'h0800);
    check("pwm2 below", o_compare_reference_level, 1'b0);
    step(c + 16'h0800);
    check("pwm2 above", o_compare_reference_level, 1'b1);
    pulse_trig();
    check("fast trigger pwm2", o_compare_reference_level, 1'b0);
    $display("test pwm done");

    // clock enable low must freeze toggling on a held match
    wr(`TOCM_ADR_MODE, mw(2'h0, 1'b0, 1'b0, 3'h3));
    @(posedge i_sys_clk);
    i_ce <= 1'b0;
    i_cnt <= c;
    repeat (3) @(posedge i_sys_clk);
    i_ce <= 1'b1;
    i_cnt <= c + 16'h0800;
    #1;
    check("enable low freezes", o_compare_reference_level, 1'b0);
    step(c);
    check("enable high toggles", o_compare_reference_level, 1'b1);
    $display("test clock enable done");
    results();
  end
endmodule
